// File: src/aop_defines.vh
// Constants for the axis output port and stop input block
// Functional notes
// - Four outputs per axis: one shared with clear, three from port registers.
// - Reset turns every general output and the shared output OFF.
// - After start each port is an output with all bits OFF.
// - Three port registers at consecutive indices map outputs, axis X output 1 first.
// - Port bit one drives ON, zero OFF; software keeps other bits by read-modify-write.
// - Reading a port register returns the output data being driven.
// - With enable set, shared output follows its control bit.
// - In clear mode the shared output carries the home search clear pulse.
// - Board output is ON exactly when internal output is high.
// - Each axis has positive and negative limits stopping that direction.
// - Limits are active low after reset.
// - Mode register two bit 3 selects limit polarity, zero meaning active low.
// - Limit and stop inputs are filtered, delay 512 us at reset, software changeable.
// - Three stop inputs per axis: near home, home and Z phase.
// - Each stop input has enable and level; active enabled stop halts driving.
// - Stop during accel or decel decelerates; during constant speed stops at once.
// - All stop inputs are disabled after reset.
// - Mode register one bits 1,0 = 1,0 enable near home stop active low.
// - Stop input levels are always readable through input registers one and two.
`ifndef AOP_DEFINES_VH
`define AOP_DEFINES_VH

// =====================================================
// Register indices, byte address is four times index
`define AOP_IDX_PORT_A   6'h14
`define AOP_IDX_PORT_B   6'h15
`define AOP_IDX_PORT_C   6'h16
`define AOP_IDX_MODE1    6'h20
`define AOP_IDX_MODE2    6'h28
`define AOP_IDX_MODE5    6'h30
`define AOP_IDX_OUTCTL   6'h38
`define AOP_IDX_INPUT1   6'h39
`define AOP_IDX_INPUT2   6'h3a
`define AOP_IDX_FILTER   6'h3b

// =====================================================
// Field positions
`define AOP_M1_STOP0_EN  1
`define AOP_M1_STOP0_LV  0
`define AOP_M1_STOP1_EN  3
`define AOP_M1_STOP1_LV  2
`define AOP_M1_ZPHASE_STOP_EN  5
`define AOP_M1_ZPHASE_STOP_LV  4
`define AOP_M2_LIM_POL   3
`define AOP_M5_OUT_EN    0
`define AOP_M5_CLR_EN    1

// =====================================================
// Reset values and timing
`define AOP_PORT_RESET   8'h00
`define AOP_MODE_RESET   8'h00
`define AOP_CLK_MHZ      40
`define AOP_FILTER_US    512
`define AOP_CYC_PER_US   (`AOP_CLK_MHZ)

`endif

// File: src/aop_top.v
// Axis output ports, limit and stop inputs with APB register access
`timescale 1ns/1ps
`include "aop_defines.vh"

module aop_top #(
	parameter                  FILTER_DELAY_US = `AOP_FILTER_US
) (
	input  wire                pclk,
	input  wire                presetn,
	input  wire                psel,
	input  wire                penable,
	input  wire                pwrite,
	input  wire [7:0]          paddr,
	input  wire [31:0]         pwdata,
	output reg  [31:0]         prdata,
	output wire                pready,
	output wire                pslverr,
	input  wire [7:0]          limit_positive,
	input  wire [7:0]          limit_negative,
	input  wire [7:0]          near_home_stop,
	input  wire [7:0]          home_stop,
	input  wire [7:0]          zphase_stop,
	input  wire [7:0]          drive_busy,
	input  wire [7:0]          drive_ramping,
	input  wire [7:0]          deviation_counter_clear,
	output reg  [23:0]         gen_output_on,
	output reg  [7:0]          shared_out_or_clear,
	output reg  [7:0]          limit_block_pos,
	output reg  [7:0]          limit_block_neg,
	output reg  [7:0]          stop_decel,
	output reg  [7:0]          stop_instant
);

	// =====================================================
	// Register decode helpers
	function reg_hit;
		input [5:0] idx;
		input [5:0] base;
		input       per_axis;
		begin
			if (per_axis)
				reg_hit = (idx[5:3] == base[5:3]);
			else
				reg_hit = (idx == base);
		end
	endfunction

	localparam [15:0] FILTER_RESET = FILTER_DELAY_US[15:0];
	localparam [5:0]  US_LAST      = `AOP_CYC_PER_US - 1;

	// =====================================================
	// Register storage
	reg  [7:0]   output_port_a;
	reg  [7:0]   output_port_b;
	reg  [7:0]   output_port_c;
	reg  [7:0]   axis_mode_register_one [0:7];
	reg  [7:0]   axis_mode_register_two [0:7];
	reg  [7:0]   mode_register_five     [0:7];
	reg  [7:0]   output_control_register;
	reg  [15:0]  filter_delay_us;

	wire [5:0]   idx       = paddr[7:2];
	wire [2:0]   axis_sel  = paddr[4:2];
	wire         aligned   = (paddr[1:0] == 2'b00);
	wire         setup_ph  = psel & ~penable;
	wire         access_ph = psel & penable;
	wire         wr_go     = access_ph & pwrite & aligned;

	wire hit_a   = reg_hit(idx, `AOP_IDX_PORT_A, 1'b0);
	wire hit_b   = reg_hit(idx, `AOP_IDX_PORT_B, 1'b0);
	wire hit_c   = reg_hit(idx, `AOP_IDX_PORT_C, 1'b0);
	wire hit_m1  = reg_hit(idx, `AOP_IDX_MODE1, 1'b1);
	wire hit_m2  = reg_hit(idx, `AOP_IDX_MODE2, 1'b1);
	wire hit_m5  = reg_hit(idx, `AOP_IDX_MODE5, 1'b1);
	wire hit_oc  = reg_hit(idx, `AOP_IDX_OUTCTL, 1'b0);
	wire hit_in1 = reg_hit(idx, `AOP_IDX_INPUT1, 1'b0);
	wire hit_in2 = reg_hit(idx, `AOP_IDX_INPUT2, 1'b0);
	wire hit_flt = reg_hit(idx, `AOP_IDX_FILTER, 1'b0);
	wire mapped  = aligned & (hit_a | hit_b | hit_c | hit_m1 | hit_m2 | hit_m5
		| hit_oc | hit_in1 | hit_in2 | hit_flt);

	// Zero wait states; unmapped or misaligned answers with an error
	assign pready  = 1'b1;
	assign pslverr = access_ph & ~mapped;

	// =====================================================
	// Filtered input levels, raw pin order per axis
	wire [7:0]   filt_lim_pos;
	wire [7:0]   filt_lim_neg;
	wire [7:0]   filt_stop0;
	wire [7:0]   filt_stop1;
	wire [7:0]   filt_zphase_stop;

	// =====================================================
	// Global register writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_port_a           <= `AOP_PORT_RESET;
			output_port_b           <= `AOP_PORT_RESET;
			output_port_c           <= `AOP_PORT_RESET;
			output_control_register <= `AOP_MODE_RESET;
			filter_delay_us         <= FILTER_RESET;
		end else if (wr_go) begin
			// Full byte replaces the port, one ON and zero OFF
			if (hit_a)
				output_port_a <= pwdata[7:0];
			if (hit_b)
				output_port_b <= pwdata[7:0];
			if (hit_c)
				output_port_c <= pwdata[7:0];
			if (hit_oc)
				output_control_register <= pwdata[7:0];
			if (hit_flt)
				filter_delay_us <= pwdata[15:0];
		end
	end

	// =====================================================
	// Per-axis mode registers
	genvar a;
	generate
		for (a = 0; a < 8; a = a + 1) begin : g_mode
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					axis_mode_register_one[a] <= `AOP_MODE_RESET;
					axis_mode_register_two[a] <= `AOP_MODE_RESET;
					mode_register_five[a]     <= `AOP_MODE_RESET;
				end else if (wr_go && axis_sel == a) begin
					if (hit_m1)
						axis_mode_register_one[a] <= pwdata[7:0];
					if (hit_m2)
						axis_mode_register_two[a] <= pwdata[7:0];
					if (hit_m5)
						mode_register_five[a] <= pwdata[7:0];
				end
			end
		end
	endgenerate

	// =====================================================
	// Read data captured in the setup cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_ph) begin
			prdata <= 32'h0000_0000;
			if (!pwrite && aligned) begin
				// Ports read back the driven data
				if (hit_a)
					prdata <= {24'h00_0000, output_port_a};
				if (hit_b)
					prdata <= {24'h00_0000, output_port_b};
				if (hit_c)
					prdata <= {24'h00_0000, output_port_c};
				if (hit_m1)
					prdata <= {24'h00_0000, axis_mode_register_one[axis_sel]};
				if (hit_m2)
					prdata <= {24'h00_0000, axis_mode_register_two[axis_sel]};
				if (hit_m5)
					prdata <= {24'h00_0000, mode_register_five[axis_sel]};
				if (hit_oc)
					prdata <= {24'h00_0000, output_control_register};
				// Filtered stop levels, usable as general inputs
				if (hit_in1)
					prdata <= {16'h0000, filt_stop1, filt_stop0};
				if (hit_in2)
					prdata <= {8'h00, filt_lim_neg, filt_lim_pos, filt_zphase_stop};
				if (hit_flt)
					prdata <= {16'h0000, filter_delay_us};
			end
		end
	end

	// =====================================================
	// Microsecond tick for the input filters
	reg  [5:0]   us_count;
	reg          us_tick;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			us_count <= 6'h00;
			us_tick  <= 1'b0;
		end else begin
			us_tick <= (us_count == US_LAST);
			if (us_count == US_LAST)
				us_count <= 6'h00;
			else
				us_count <= us_count + 6'h01;
		end
	end

	// =====================================================
	// Digital filters: level must hold for the delay
	wire [39:0]  raw_in = {zphase_stop, home_stop, near_home_stop,
		limit_negative, limit_positive};
	reg  [39:0]  filt_q;

	genvar f;
	generate
		for (f = 0; f < 40; f = f + 1) begin : g_filt
			reg  [15:0] held_us;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					filt_q[f] <= 1'b1;
					held_us   <= 16'h0000;
				end else if (filter_delay_us == 16'h0000) begin
					// Zero delay bypasses the filter
					filt_q[f] <= raw_in[f];
					held_us   <= 16'h0000;
				end else if (raw_in[f] == filt_q[f]) begin
					held_us <= 16'h0000;
				end else if (us_tick) begin
					if (held_us + 16'h0001 >= filter_delay_us) begin
						filt_q[f] <= raw_in[f];
						held_us   <= 16'h0000;
					end else begin
						held_us <= held_us + 16'h0001;
					end
				end
			end
		end
	endgenerate

	assign filt_lim_pos = filt_q[7:0];
	assign filt_lim_neg = filt_q[15:8];
	assign filt_stop0   = filt_q[23:16];
	assign filt_stop1   = filt_q[31:24];
	assign filt_zphase_stop   = filt_q[39:32];

	// =====================================================
	// Per-axis limit, stop and shared output logic
	reg  [7:0]   next_lim_pos;
	reg  [7:0]   next_lim_neg;
	reg  [7:0]   next_decel;
	reg  [7:0]   next_instant;
	reg  [7:0]   next_shared;
	reg  [7:0]   m1;
	reg          lim_high;
	reg          any_stop;
	integer      i;

	// Level bit zero means active low, one active high
	always @* begin
		next_lim_pos = 8'h00;
		next_lim_neg = 8'h00;
		next_decel   = 8'h00;
		next_instant = 8'h00;
		next_shared  = 8'h00;
		m1           = 8'h00;
		lim_high     = 1'b0;
		any_stop     = 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			lim_high        = axis_mode_register_two[i][`AOP_M2_LIM_POL];
			next_lim_pos[i] = ~(filt_lim_pos[i] ^ lim_high);
			next_lim_neg[i] = ~(filt_lim_neg[i] ^ lim_high);
			m1              = axis_mode_register_one[i];
			any_stop = (m1[`AOP_M1_STOP0_EN] & ~(filt_stop0[i] ^ m1[`AOP_M1_STOP0_LV]))
				| (m1[`AOP_M1_STOP1_EN] & ~(filt_stop1[i] ^ m1[`AOP_M1_STOP1_LV]))
				| (m1[`AOP_M1_ZPHASE_STOP_EN] & ~(filt_zphase_stop[i] ^ m1[`AOP_M1_ZPHASE_STOP_LV]));
			// Ramp phase decelerates, constant speed stops at once
			next_decel[i]   = any_stop & drive_busy[i] & drive_ramping[i];
			next_instant[i] = any_stop & drive_busy[i] & ~drive_ramping[i];
			if (mode_register_five[i][`AOP_M5_OUT_EN])
				next_shared[i] = output_control_register[i];
			else if (mode_register_five[i][`AOP_M5_CLR_EN])
				next_shared[i] = deviation_counter_clear[i];
		end
	end

	// =====================================================
	// Output flip-flops, transistor ON while bit is high
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gen_output_on       <= 24'h00_0000;
			shared_out_or_clear <= 8'h00;
			limit_block_pos     <= 8'h00;
			limit_block_neg     <= 8'h00;
			stop_decel          <= 8'h00;
			stop_instant        <= 8'h00;
		end else begin
			gen_output_on       <= {output_port_c, output_port_b, output_port_a};
			shared_out_or_clear <= next_shared;
			limit_block_pos     <= next_lim_pos;
			limit_block_neg     <= next_lim_neg;
			stop_decel          <= next_decel;
			stop_instant        <= next_instant;
		end
	end

endmodule // aop_top

// File: tb/aop_field_model.sv
// Limit and stop sensors on the far side of the block
`timescale 1ns/1ps

module aop_field_model (
	input  wire       pclk,
	input  wire [7:0] trip_pos,
	input  wire [7:0] trip_neg,
	input  wire [7:0] trip_s0,
	input  wire [7:0] trip_s1,
	input  wire [7:0] trip_s2,
	output reg  [7:0] limit_positive = 8'hff,
	output reg  [7:0] limit_negative = 8'hff,
	output reg  [7:0] near_home_stop = 8'hff,
	output reg  [7:0] home_stop      = 8'hff,
	output reg  [7:0] zphase_stop    = 8'hff
);
	// Tripped sensor sinks current, so its pin reads low
	always @(posedge pclk) begin
		limit_positive <= ~trip_pos;
		limit_negative <= ~trip_neg;
		near_home_stop <= ~trip_s0;
		home_stop      <= ~trip_s1;
		zphase_stop    <= ~trip_s2;
	end
endmodule // aop_field_model

// File: tb/aop_monitor.sv
// Concurrent checks on the ports of the axis output port block
`timescale 1ns/1ps

module aop_monitor #(
	parameter          FILTER_DELAY_US = 512
) (
	input wire         pclk,
	input wire         presetn,
	input wire         psel,
	input wire         penable,
	input wire         pwrite,
	input wire [7:0]   paddr,
	input wire [31:0]  pwdata,
	input wire [31:0]  prdata,
	input wire         pslverr,
	input wire [7:0]   drive_busy,
	input wire [23:0]  gen_output_on,
	input wire [7:0]   shared_out_or_clear,
	input wire [7:0]   stop_decel,
	input wire [7:0]   stop_instant
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// =====================================================
	// Register path
	wire acc = psel && penable;

	a_slverr_misalign: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access without slave error");
	// Port register loads at the access edge, output flop one edge later
	a_port_a_write: assert property (acc && pwrite && paddr == 8'h50
		|-> ##2 gen_output_on[7:0] == $past(pwdata[7:0], 2)) else $error("port a not driven");
	a_port_b_write: assert property (acc && pwrite && paddr == 8'h54
		|-> ##2 gen_output_on[15:8] == $past(pwdata[7:0], 2)) else $error("port b not driven");
	a_port_c_write: assert property (acc && pwrite && paddr == 8'h58
		|-> ##2 gen_output_on[23:16] == $past(pwdata[7:0], 2)) else $error("port c not driven");
	a_port_readback: assert property (psel && !penable && !pwrite && paddr == 8'h50
		|=> prdata == {24'h0, gen_output_on[7:0]}) else $error("port a readback wrong");

	// =====================================================
	// Stop and reset behaviour
	a_stop_exclusive: assert property ((stop_decel & stop_instant) == 8'h00)
		else $error("decel and instant stop together");
	a_stop_idle: assert property (((stop_decel | stop_instant) & ~$past(drive_busy)
		& ~$past(drive_busy, 2)) == 8'h00) else $error("stop while not driving");
	a_reset_off: assert property (disable iff (1'b0) !presetn
		|-> gen_output_on == 24'h0 && shared_out_or_clear == 8'h00) else $error("output on in reset");
endmodule // aop_monitor

bind aop_top aop_monitor #(.FILTER_DELAY_US(FILTER_DELAY_US)) aop_monitor_inst (.*);

// File: tb/testbench.sv
// Self-checking bench for the axis output port block
`timescale 1ns/1ps

module testbench;
	reg         pclk = 1'b0;
	reg         presetn = 1'b1;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [7:0]  paddr = 8'h00;
	reg  [31:0] pwdata = 32'h0;
	reg  [7:0]  drive_busy = 8'h00;
	reg  [7:0]  drive_ramping = 8'h00;
	reg  [7:0]  deviation_counter_clear = 8'h00;
	reg  [7:0]  trip_pos = 8'h00, trip_neg = 8'h00;
	reg  [7:0]  trip_s0 = 8'h00, trip_s1 = 8'h00, trip_s2 = 8'h00;
	wire [31:0] prdata;
	wire        pready, pslverr;
	wire [7:0]  limit_positive, limit_negative, near_home_stop, home_stop, zphase_stop;
	wire [23:0] gen_output_on;
	wire [7:0]  shared_out_or_clear, limit_block_pos, limit_block_neg, stop_decel, stop_instant;
	reg  [31:0] rdv;
	reg         err;
	integer     errors = 0;
	integer     comparisons = 0;
	integer     i;

	aop_top aop_top_inst (.*);
	aop_field_model aop_field_model_inst (.*);

	always #12.5 pclk = ~pclk;

	// =====================================================
	// Shared tasks
	task chk(input string nm, input [31:0] exp, input [31:0] got);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("mismatch %s expected %h seen %h", nm, exp, got);
			end
		end
	endtask

	// One APB transfer, held until pready at a rising edge
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			do @(posedge pclk); while (pready !== 1'b1);
			rdv = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task cyc(input integer n);
		repeat (n) @(posedge pclk);
	endtask

	task test_done;
		begin
			$display("counts errors %0d comparisons %0d", errors, comparisons);
			if (errors == 0 && comparisons > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask

	// =====================================================
	// Scenarios
	task t_reset_state;
		begin
			chk("outputs", 32'h0, {8'h0, gen_output_on});
			chk("shared", 32'h0, {24'h0, shared_out_or_clear});
			for (i = 0; i < 3; i = i + 1) begin
				apb(1'b0, 8'h50 + 4 * i, 32'h0);
				chk("port_reset", 32'h0, rdv);
			end
			apb(1'b0, 8'hec, 32'h0);
			chk("filter_reset", 32'h200, rdv);
			$display("test reset_state done");
		end
	endtask

	task t_ports;
		begin
			for (i = 0; i < 3; i = i + 1) begin
				apb(1'b1, 8'h50 + 4 * i, 32'ha4 + i);
				cyc(2);
				chk("port_out", 32'ha4 + i, {24'h0, gen_output_on[8*i +: 8]});
				apb(1'b0, 8'h50 + 4 * i, 32'h0);
				chk("port_read", 32'ha4 + i, rdv);
				apb(1'b1, 8'h50 + 4 * i, rdv | 32'h1);
				cyc(2);
				chk("port_rmw", (32'ha4 + i) | 32'h1, {24'h0, gen_output_on[8*i +: 8]});
			end
			apb(1'b1, 8'h5c, 32'hff);
			chk("unmapped_err", 32'h1, {31'h0, err});
			apb(1'b1, 8'h52, 32'hff);
			chk("misalign_err", 32'h1, {31'h0, err});
			chk("port_kept", 32'ha5, {24'h0, gen_output_on[7:0]});
			$display("test ports done");
		end
	endtask

	task t_shared;
		begin
			apb(1'b1, 8'hc0, 32'h1);
			apb(1'b1, 8'he0, 32'h3);
			cyc(2);
			chk("shared_on", 32'h1, {24'h0, shared_out_or_clear});
			apb(1'b1, 8'he0, 32'h0);
			cyc(2);
			chk("shared_off", 32'h0, {24'h0, shared_out_or_clear});
			apb(1'b1, 8'hc4, 32'h2);
			deviation_counter_clear <= 8'h02;
			cyc(3);
			chk("clear_on", 32'h2, {24'h0, shared_out_or_clear});
			deviation_counter_clear <= 8'h00;
			cyc(3);
			chk("clear_off", 32'h0, {24'h0, shared_out_or_clear});
			$display("test shared done");
		end
	endtask

	task t_limits;
		begin
			apb(1'b1, 8'hec, 32'h0);
			trip_pos <= 8'h01;
			trip_neg <= 8'h04;
			cyc(8);
			chk("lim_pos", 32'h01, {24'h0, limit_block_pos});
			chk("lim_neg", 32'h04, {24'h0, limit_block_neg});
			apb(1'b0, 8'he8, 32'h0);
			chk("input_two", 32'h00fbfeff, rdv);
			apb(1'b1, 8'ha0, 32'h8);
			cyc(4);
			chk("pol_pos", 32'h00, {24'h0, limit_block_pos});
			chk("pol_neg", 32'h05, {24'h0, limit_block_neg});
			apb(1'b1, 8'ha0, 32'h0);
			trip_pos <= 8'h00;
			trip_neg <= 8'h00;
			$display("test limits done");
		end
	endtask

	task t_stops;
		begin
			trip_s0 <= 8'h01;
			drive_busy <= 8'h01;
			drive_ramping <= 8'h01;
			cyc(6);
			chk("stop_disabled", 32'h0, {24'h0, stop_decel});
			apb(1'b0, 8'he4, 32'h0);
			chk("input_one", 32'h0000fffe, rdv);
			apb(1'b1, 8'h80, 32'h2);
			cyc(6);
			chk("stop_decel", 32'h1, {24'h0, stop_decel});
			drive_ramping <= 8'h00;
			cyc(4);
			chk("stop_instant", 32'h1, {24'h0, stop_instant});
			drive_busy <= 8'h00;
			cyc(4);
			chk("stop_idle", 32'h0, {24'h0, stop_instant | stop_decel});
			// Two microsecond filter: change needs at least 41 cycles
			apb(1'b1, 8'hec, 32'h2);
			trip_s1 <= 8'h01;
			cyc(30);
			apb(1'b0, 8'he4, 32'h0);
			chk("filter_hold", 32'h0000fffe, rdv);
			cyc(100);
			apb(1'b0, 8'he4, 32'h0);
			chk("filter_pass", 32'h0000fefe, rdv);
			$display("test stops done");
		end
	endtask

	// =====================================================
	// Main sequence and watchdog
	initial begin
		presetn <= 1'b0;
		cyc(10);
		presetn <= 1'b1;
		t_reset_state;
		t_ports;
		t_shared;
		t_limits;
		t_stops;
		test_done;
	end

	initial begin
		cyc(20000);
		errors = errors + 1;
		test_done;
	end
endmodule // testbench
